//--- sfp_access.sv
`timescale 1ns/1ns
// Contract
// - writes refused unless write enable latch set
// - write-protect low blocks array and status writes
// - latch set, pin high: only unprotected addresses
// - status: protect bits 3:2, latch bit 1
// - bit 0 never busy, always zero
// - protect bits kept nonvolatile across power loss
// - latch set by enable, cleared by disable/write end
// - protect codes select none, 180h, 100h, all
// - status write needs latch and pin high
// - unlimited data bytes per array write, no waiting
// - opcode bit 3 plus next byte form address
// - address advances per byte, wraps 1FFh to 000h
// - byte stored right after its eighth bit
// - transfer runs until chip select rises
// - read ignores data input, shifts out msb first
// - write data msb first into bit 7
// - hold low pauses, hold high resumes command
// - fixed command byte encodings
// - sample on rising, drive on falling, bytes
// - latch cleared at power-up
module sfp_access
    import sfp_pkg::*;
(
    // system clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_n_i,
    // serial link pins
    input  wire logic                sck_i,
    input  wire logic                cs_n_i,
    input  wire logic                si_i,
    input  wire logic                hold_n_i,
    input  wire logic                wp_n_i,
    output logic                     so_o,
    output logic                     so_oe_o,
    // nonvolatile protect cell
    input  wire logic [1:0]          nv_bp_i,
    output logic [1:0]               nv_bp_o,
    // system-side view
    output logic                     commit_o,
    output logic [ADDR_W-1:0]        commit_addr_o,
    output logic [DATA_W-1:0]        commit_data_o,
    output logic [7:0]               status_o
);

    // link-side state
    sfp_phase_t          phase;         // frame phase
    logic [2:0]          bit_cnt;       // bits taken in current byte
    logic [7:0]          shreg;         // incoming bits
    logic [7:0]          opcode;        // last complete command byte
    logic                op_valid;      // command byte complete this frame
    logic [ADDR_W-1:0]   addr;          // running array address
    logic                write_enable_latch;           // write enable latch
    logic [1:0]          bp_q;          // protect bits last written
    logic                bp_valid;      // bp_q written since reset
    logic [1:0]          bp_eff;        // protect bits in force
    logic                so_q;          // output bit register
    logic                so_en;         // output phase flag
    logic [DATA_W-1:0]   mem [0:MEM_DEPTH-1];  // storage array

    // decoded link terms
    logic                active;        // selected and not held
    logic                byte_end;      // eighth bit on this edge
    logic [7:0]          rx_byte;       // byte completed with si_i
    logic                op_rd_mem;     // read memory command
    logic                op_wr_mem;     // write memory command
    logic                op_rd_sr;      // read status command
    logic                op_wr_sr;      // write status command
    logic                mem_we;        // array write strobe
    logic                sr_we;         // status write strobe
    logic [7:0]          status_byte;   // assembled status value
    logic [7:0]          out_byte;      // byte being shifted out
    logic [2:0]          out_idx;       // bit index to drive

    // crossing to the system clock
    logic                cm_tgl;        // flips per committed byte
    sfp_commit_t         cm_rec;        // last committed byte
    logic [2:0]          cm_sync;       // toggle synchroniser plus edge stage
    logic [7:0]          st_s1;         // status first stage
    logic [7:0]          st_s2;         // status second stage
    logic [7:0]          st_s3;         // status agreement stage

    // basic decode
    always_comb begin
        active    = !cs_n_i && hold_n_i;
        byte_end  = (bit_cnt == LAST_BIT);
        rx_byte   = {shreg[6:0], si_i};
        op_rd_mem = (opcode[7:4] == MEM_CMD_HI) && (opcode[2:0] == READ_MEM_LO);
        op_wr_mem = (opcode[7:4] == MEM_CMD_HI) && (opcode[2:0] == WRITE_MEM_LO);
        op_rd_sr  = (opcode == READ_STATUS_CMD);
        op_wr_sr  = (opcode == WRITE_STATUS_CMD);
    end

    // protect bits: restored cell value until the first status write
    always_comb begin
        bp_eff  = bp_valid ? bp_q : nv_bp_i;
        nv_bp_o = bp_eff;
    end

    // status byte: fixed zero bits, protect bits and latch
    always_comb begin
        status_byte               = SR_RESET;
        status_byte[SR_BUSY_BIT]  = 1'b0;
        status_byte[SR_WEL_BIT]   = write_enable_latch;
        status_byte[SR_BP_LO_BIT] = bp_eff[0];
        status_byte[SR_BP_HI_BIT] = bp_eff[1];
    end

    // write strobes, gated by latch and pin; array strobe also by protected range
    always_comb begin
        mem_we = active && byte_end && (phase == PH_DATA) && op_wr_mem
                 && write_enable_latch && wp_n_i && !sfp_is_protected(bp_eff, addr);
        sr_we  = active && byte_end && (phase == PH_DATA) && op_wr_sr
                 && write_enable_latch && wp_n_i;
    end

    // bit counter and phase, cleared whenever chip select is high
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            bit_cnt  <= 3'h0;
            phase    <= PH_OP;
            op_valid <= 1'b0;
        end else if (hold_n_i) begin
            bit_cnt <= bit_cnt + 3'h1;
            if (byte_end) begin
                case (phase)
                    PH_OP: begin
                        op_valid <= 1'b1;
                        // memory commands take an address byte next
                        if ((rx_byte[7:4] == MEM_CMD_HI) && (rx_byte[2:1] == 2'h1)) begin
                            phase <= PH_ADDR;
                        end else if ((rx_byte == READ_STATUS_CMD) || (rx_byte == WRITE_STATUS_CMD)) begin
                            phase <= PH_DATA;
                        end else begin
                            phase <= PH_IDLE;
                        end
                    end
                    PH_ADDR: begin
                        phase <= PH_DATA;
                    end
                    PH_DATA: begin
                        // status write takes one byte, others stream on
                        phase <= op_wr_sr ? PH_IDLE : PH_DATA;
                    end
                    default: begin
                        phase <= PH_IDLE;
                    end
                endcase
            end
        end
    end

    // input shift register, msb arrives first
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            shreg <= 8'h00;
        end else if (hold_n_i) begin
            shreg <= rx_byte;
        end
    end

    // command byte capture, kept past the frame end
    always_ff @(posedge sck_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            opcode <= 8'h00;
        end else if (active && byte_end && (phase == PH_OP)) begin
            opcode <= rx_byte;
        end
    end

    // address load from command and address bytes, then advance
    always_ff @(posedge sck_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr <= 9'h000;
        end else if (active && byte_end) begin
            case (phase)
                PH_OP: begin
                    addr <= {rx_byte[CMD_ADDR_BIT], 8'h00};
                end
                PH_ADDR: begin
                    addr[7:0] <= rx_byte;
                end
                PH_DATA: begin
                    // advance even on dropped bytes; 9 bits wrap 1FFh to 000h
                    if (op_rd_mem || op_wr_mem) begin
                        addr <= addr + 9'h001;
                    end
                end
                default: begin
                    addr <= addr;
                end
            endcase
        end
    end

    // array write on the eighth bit of each data byte
    always_ff @(posedge sck_i) begin
        if (mem_we) begin
            mem[addr] <= rx_byte;
        end
    end

    // protect bit storage, not cleared by reset
    always_ff @(posedge sck_i) begin
        if (sr_we) begin
            bp_q <= {rx_byte[SR_BP_HI_BIT], rx_byte[SR_BP_LO_BIT]};
        end
    end

    // marks that bp_q holds a written value
    always_ff @(posedge sck_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bp_valid <= 1'b0;
        end else if (sr_we) begin
            bp_valid <= 1'b1;
        end
    end

    // latch updates when chip select rises at a frame end
    always_ff @(posedge cs_n_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            write_enable_latch <= 1'b0;
        end else if (op_valid) begin
            if (opcode == SET_WRITE_ENABLE_CMD) begin
                write_enable_latch <= 1'b1;
            end else if ((opcode == WRITE_DISABLE_CMD) || op_wr_sr || op_wr_mem) begin
                write_enable_latch <= 1'b0;
            end
        end
    end

    // output byte and bit select
    always_comb begin
        out_byte = op_rd_sr ? status_byte : mem[addr];
        out_idx  = LAST_BIT - bit_cnt;
    end

    // serial output changes on the falling clock edge
    always_ff @(negedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            so_q  <= 1'b0;
            so_en <= 1'b0;
        end else if (hold_n_i) begin
            so_en <= (phase == PH_DATA) && (op_rd_mem || op_rd_sr);
            so_q  <= out_byte[out_idx];
        end
    end

    // pin drive: released when deselected or held
    always_comb begin
        so_o    = so_q;
        so_oe_o = so_en && !cs_n_i && hold_n_i;
    end

    // commit record and event toggle on the link side
    always_ff @(posedge sck_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cm_tgl <= 1'b0;
            cm_rec <= '0;
        end else if (mem_we) begin
            cm_tgl      <= ~cm_tgl;
            cm_rec.addr <= addr;
            cm_rec.data <= rx_byte;
        end
    end

    // toggle synchroniser; only the last two stages are compared
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cm_sync <= 3'h0;
        end else begin
            cm_sync <= {cm_sync[1:0], cm_tgl};
        end
    end

    // commit pulse and captured record on the system clock
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            commit_o      <= 1'b0;
            commit_addr_o <= 9'h000;
            commit_data_o <= 8'h00;
        end else begin
            commit_o <= cm_sync[2] ^ cm_sync[1];
            if (cm_sync[2] ^ cm_sync[1]) begin
                commit_addr_o <= cm_rec.addr;
                commit_data_o <= cm_rec.data;
            end
        end
    end

    // status word over two flip-flops, then passed only when two samples agree
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_s1    <= SR_RESET;
            st_s2    <= SR_RESET;
            st_s3    <= SR_RESET;
            status_o <= SR_RESET;
        end else begin
            st_s1    <= status_byte;
            st_s2    <= st_s1;
            st_s3    <= st_s2;
            if (st_s3 == st_s2) begin  // a word torn mid-change never reaches the output
                status_o <= st_s3;
            end
        end
    end

    // one data byte finishing in a memory command
    sequence s_mem_byte_end;
        active && byte_end && (phase == PH_DATA) && (op_rd_mem || op_wr_mem);
    endsequence

    // one array write strobe
    sequence s_array_store;
        mem_we;
    endsequence

    chk_wel_gate: assert property (@(posedge sck_i) disable iff (cs_n_i || !rst_n_i)
        (mem_we || sr_we) |-> write_enable_latch)
        else $error("write strobe with latch clear");

    chk_wp_block: assert property (@(posedge sck_i) disable iff (cs_n_i || !rst_n_i)
        !wp_n_i |-> !(mem_we || sr_we))
        else $error("write strobe while write protect low");

    chk_range_guard: assert property (@(posedge sck_i) disable iff (cs_n_i || !rst_n_i)
        mem_we |-> !sfp_is_protected(bp_eff, addr))
        else $error("array write inside protected range");

    chk_status_zero: assert property (@(posedge sck_i) disable iff (cs_n_i || !rst_n_i)
        (status_byte[7:4] == 4'h0) && (status_byte[SR_WEL_BIT] == write_enable_latch))
        else $error("status byte layout wrong");

    chk_never_busy: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        status_o[SR_BUSY_BIT] == 1'b0)
        else $error("status reports busy");

    chk_addr_wrap: assert property (@(posedge sck_i) disable iff (cs_n_i || !rst_n_i)
        s_mem_byte_end |=> (addr == $past(addr) + 9'h001))
        else $error("address did not advance by one");

    chk_commit_data: assert property (@(posedge sck_i) disable iff (cs_n_i || !rst_n_i)
        s_array_store |=> (mem[$past(addr)] == $past(rx_byte)))
        else $error("array byte not stored");

    chk_hold_freeze: assert property (@(posedge sck_i) disable iff (cs_n_i || !rst_n_i)
        !hold_n_i |=> (bit_cnt == $past(bit_cnt)))
        else $error("bit counter moved during hold");

    chk_wel_update: assert property (@(posedge cs_n_i) disable iff (!rst_n_i)
        (op_valid && (op_wr_mem || op_wr_sr)) |=> !write_enable_latch)
        else $error("latch not cleared after write command");

    chk_so_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        so_oe_o |-> (!cs_n_i && hold_n_i && (phase == PH_DATA) && (op_rd_mem || op_rd_sr)))
        else $error("output driven outside read data phase");

endmodule : sfp_access

//--- sfp_access_test.sv
`timescale 1ns/1ns
module sfp_access_test
    import sfp_pkg::*;
();
    // one write attempt: enable, pin, protect code, address, data, stored
    typedef struct packed {
        logic       en;
        logic       wp;
        logic [1:0] bp;
        logic [8:0] a;
        logic [7:0] d;
        logic       ex;
    } sfp_row_t;

    logic              clk_i;
    logic              rst_n_i;
    logic              sck, cs_n, si, hold_n;
    logic              wp_n_i;
    logic [1:0]        nv_bp_i;
    logic              so_o, so_oe_o, commit_o;
    logic [1:0]        nv_bp_o;
    logic [ADDR_W-1:0] commit_addr_o;
    logic [DATA_W-1:0] commit_data_o;
    logic [7:0]        status_o;
    int                num_errors = 0;
    int                n_tests    = 0;
    int                n_commit   = 0;
    int                base;
    sfp_row_t          rows [8] = '{
        '{1'b0, 1'b1, 2'h0, 9'h005, 8'h5A, 1'b0},
        '{1'b1, 1'b0, 2'h0, 9'h006, 8'hA5, 1'b0},
        '{1'b1, 1'b1, 2'h1, 9'h17F, 8'h11, 1'b1},
        '{1'b1, 1'b1, 2'h1, 9'h180, 8'h22, 1'b0},
        '{1'b1, 1'b1, 2'h2, 9'h0FF, 8'h33, 1'b1},
        '{1'b1, 1'b1, 2'h2, 9'h100, 8'h44, 1'b0},
        '{1'b1, 1'b1, 2'h3, 9'h000, 8'h55, 1'b0},
        '{1'b1, 1'b1, 2'h0, 9'h1FF, 8'h66, 1'b1}
    };

    sfp_access sfp_access_i (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
        .hold_n_i(hold_n), .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o),
        .nv_bp_i(nv_bp_i), .nv_bp_o(nv_bp_o), .commit_o(commit_o),
        .commit_addr_o(commit_addr_o), .commit_data_o(commit_data_o), .status_o(status_o)
    );
    sfp_host_model sfp_host_model_i (
        .sck_o(sck), .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n),
        .so_i(so_o), .so_oe_i(so_oe_o)
    );

    // system clock
    initial clk_i = 1'b0;
    always #5 clk_i = ~clk_i;

    // count stored bytes as the system side sees them
    always @(posedge clk_i) begin
        if (commit_o === 1'b1) begin
            n_commit <= n_commit + 1;
        end
    end

    // verdict and end of run
    task tally_and_finish();
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // compare one result
    task chk(input logic [16:0] got, input logic [16:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // let the crossing to the system clock land
    task settle();
        repeat (10) @(posedge clk_i);
    endtask : settle

    // one-byte command frame
    task cmd(input logic [7:0] op);
        logic [7:0] rx;
        sfp_host_model_i.begin_frame();
        sfp_host_model_i.xfer(op, 8, 8, rx);
        sfp_host_model_i.end_frame();
        settle();
    endtask : cmd

    // memory write of n bytes, the last one cut to nb bits
    task wr(input logic [8:0] a, input logic [7:0] d0, input int n, input int nb);
        logic [7:0] rx;
        sfp_host_model_i.begin_frame();
        sfp_host_model_i.xfer({MEM_CMD_HI, a[8], WRITE_MEM_LO}, 8, 8, rx);
        sfp_host_model_i.xfer(a[7:0], 8, 8, rx);
        for (int i = 0; i < n; i++) begin
            sfp_host_model_i.xfer(d0 + 8'(i), (i == n - 1) ? nb : 8, 8, rx);
        end
        sfp_host_model_i.end_frame();
        settle();
    endtask : wr

    // memory read of n bytes with inverted data on si, pause at bit hb of byte 0
    task rd(input logic [8:0] a, input logic [7:0] d0, input int n, input int hb);
        logic [7:0] rx;
        sfp_host_model_i.begin_frame();
        sfp_host_model_i.xfer({MEM_CMD_HI, a[8], READ_MEM_LO}, 8, 8, rx);
        sfp_host_model_i.xfer(a[7:0], 8, 8, rx);
        for (int i = 0; i < n; i++) begin
            sfp_host_model_i.xfer(~(d0 + 8'(i)), 8, (i == 0) ? hb : 8, rx);
            chk(17'(rx), 17'(d0 + 8'(i)), "read data");
        end
        sfp_host_model_i.end_frame();
        chk(17'(so_oe_o), 17'h0, "output released");
    endtask : rd

    // status read and status write frames
    task rs(input logic [7:0] exp);
        logic [7:0] rx;
        sfp_host_model_i.begin_frame();
        sfp_host_model_i.xfer(READ_STATUS_CMD, 8, 8, rx);
        sfp_host_model_i.xfer(8'hFF, 8, 8, rx);
        sfp_host_model_i.end_frame();
        chk(17'(rx), 17'(exp), "status byte");
    endtask : rs
    task ws(input logic [7:0] v);
        logic [7:0] rx;
        sfp_host_model_i.begin_frame();
        sfp_host_model_i.xfer(WRITE_STATUS_CMD, 8, 8, rx);
        sfp_host_model_i.xfer(v, 8, 8, rx);
        sfp_host_model_i.end_frame();
        settle();
    endtask : ws

    // watchdog, far beyond the expected run of some 25 us
    initial begin
        #500000;
        num_errors++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        tally_and_finish();
    end

    // main sequence
    initial begin
        rst_n_i <= 1'b0;
        wp_n_i  <= 1'b1;
        nv_bp_i <= BP_NONE;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        settle();
        chk({status_o, commit_o, so_oe_o, 7'h0}, 17'h0, "after reset");
        // write attempts from the table
        foreach (rows[k]) begin
            wp_n_i  <= rows[k].wp;
            nv_bp_i <= rows[k].bp;
            @(posedge clk_i);
            if (rows[k].en) begin
                cmd(SET_WRITE_ENABLE_CMD);
            end
            base = n_commit;
            wr(rows[k].a, rows[k].d, 1, 8);
            chk(17'(n_commit - base), 17'(rows[k].ex), "commit count");
            if (rows[k].ex) begin
                chk({commit_addr_o, commit_data_o}, {rows[k].a, rows[k].d}, "commit");
            end
        end
        // burst across the top of the array, then read it back with a pause
        wp_n_i  <= 1'b1;
        nv_bp_i <= BP_NONE;
        @(posedge clk_i);
        cmd(SET_WRITE_ENABLE_CMD);
        base = n_commit;
        wr(9'h1FE, 8'hC1, 3, 8);
        chk(17'(n_commit - base), 17'h3, "burst count");
        chk({commit_addr_o, commit_data_o}, {9'h000, 8'hC3}, "wrap");
        rd(9'h1FE, 8'hC1, 3, 3);
        chk(17'(sfp_host_model_i.hold_oe), 17'h0, "released in pause");
        // protected byte skipped, next lands after the wrap
        nv_bp_i <= BP_QUARTER;
        @(posedge clk_i);
        cmd(SET_WRITE_ENABLE_CMD);
        base = n_commit;
        wr(9'h1FF, 8'h70, 2, 8);
        chk(17'(n_commit - base), 17'h1, "skip count");
        chk({commit_addr_o, commit_data_o}, {9'h000, 8'h71}, "skip");
        // byte cut short by deselect
        nv_bp_i <= BP_NONE;
        @(posedge clk_i);
        cmd(SET_WRITE_ENABLE_CMD);
        base = n_commit;
        wr(9'h010, 8'h99, 1, 4);
        chk(17'(n_commit - base), 17'h0, "partial byte");
        rs(8'h00);
        // status register writes and the latch
        cmd(SET_WRITE_ENABLE_CMD);
        ws(8'hFF);
        rs(8'h0C);
        chk(17'(nv_bp_o), 17'h3, "protect write back");
        chk(17'(status_o), 17'h0C, "status view");
        cmd(SET_WRITE_ENABLE_CMD);
        rs(8'h0E);
        cmd(WRITE_DISABLE_CMD);
        rs(8'h0C);
        wp_n_i <= 1'b0;
        @(posedge clk_i);
        cmd(SET_WRITE_ENABLE_CMD);
        ws(8'h00);
        rs(8'h0C);
        wp_n_i <= 1'b1;
        @(posedge clk_i);
        cmd(SET_WRITE_ENABLE_CMD);
        ws(8'h00);
        rs(8'h00);
        // reset in mid-run: latch cleared, protect bits from the cell
        cmd(SET_WRITE_ENABLE_CMD);
        nv_bp_i <= BP_HALF;
        rst_n_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        settle();
        rs(8'h08);
        tally_and_finish();
    end
endmodule : sfp_access_test

//--- sfp_host_model.sv
`timescale 1ns/1ns
// host side of the serial link: mode 0, clock parked low outside frames
module sfp_host_model (
    // link pins driven by the host
    output logic      sck_o,
    output logic      cs_n_o,
    output logic      si_o,
    output logic      hold_n_o,
    // device answer
    input  wire logic so_i,
    input  wire logic so_oe_i
);
    logic last_bit; // last level seen on the data-out line
    logic hold_oe;  // sticky: output seen enabled during a pause

    // idle levels at time zero
    initial begin
        sck_o    <= 1'b0;
        cs_n_o   <= 1'b1;
        si_o     <= 1'b0;
        hold_n_o <= 1'b1;
        last_bit = 1'b0;
        hold_oe  = 1'b0;
    end

    // open a frame; odd lead keeps link edges off the system clock edges
    task begin_frame();
        cs_n_o = 1'b0;
        #17;
    endtask : begin_frame

    // close the frame with the clock low, then keep a deselect gap
    task end_frame();
        #15;
        cs_n_o = 1'b1;
        #45;
    endtask : end_frame

    // shift nb bits msb first; before bit hb pause for two clocks
    task xfer(input logic [7:0] tx, input int nb, input int hb, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < nb; i++) begin
            if (i == hb) begin
                #5 hold_n_o = 1'b0;
                repeat (2) begin
                    #15 sck_o = 1'b1;
                    hold_oe = hold_oe | so_oe_i;
                    #15 sck_o = 1'b0;
                end
                #5 hold_n_o = 1'b1;
            end
            si_o = tx[7-i];
            #15 sck_o = 1'b1;
            // a released line shows the inverse of its last level
            last_bit = so_oe_i ? so_i : ~last_bit;
            rx[7-i] = last_bit;
            #15 sck_o = 1'b0;
        end
    endtask : xfer
endmodule : sfp_host_model

//--- sfp_pkg.sv
package sfp_pkg;

    // command byte encodings
    localparam logic [7:0] SET_WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] WRITE_DISABLE_CMD    = 8'h04;
    localparam logic [7:0] READ_STATUS_CMD      = 8'h05;
    localparam logic [7:0] WRITE_STATUS_CMD     = 8'h01;
    // memory commands: upper nibble zero, bit 3 carries address bit 8
    localparam logic [3:0] MEM_CMD_HI           = 4'h0;
    localparam logic [2:0] READ_MEM_LO          = 3'h3;
    localparam logic [2:0] WRITE_MEM_LO         = 3'h2;
    localparam int         CMD_ADDR_BIT         = 3;

    // array geometry
    localparam int         ADDR_W               = 9;
    localparam int         DATA_W               = 8;
    localparam int         MEM_DEPTH            = 512;

    // protect_status field positions
    localparam int         SR_BUSY_BIT          = 0;
    localparam int         SR_WEL_BIT           = 1;
    localparam int         SR_BP_LO_BIT         = 2;
    localparam int         SR_BP_HI_BIT         = 3;
    localparam logic [7:0] SR_RESET             = 8'h00;

    // block protect encodings and range bases
    localparam logic [1:0] BP_NONE              = 2'h0;
    localparam logic [1:0] BP_QUARTER           = 2'h1;
    localparam logic [1:0] BP_HALF              = 2'h2;
    localparam logic [1:0] BP_ALL               = 2'h3;
    localparam logic [8:0] PROT_QUARTER_BASE    = 9'h180;
    localparam logic [8:0] PROT_HALF_BASE       = 9'h100;

    // bit counter value on the last bit of a byte
    localparam logic [2:0] LAST_BIT             = 3'h7;

    // transfer phases inside one chip-select frame
    typedef enum logic [3:0] {
        PH_OP   = 4'h1,
        PH_ADDR = 4'h2,
        PH_DATA = 4'h4,
        PH_IDLE = 4'h8
    } sfp_phase_t;

    // one committed array byte, passed to the system side
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } sfp_commit_t;

    // true when the address lies in the range chosen by the protect bits
    function automatic logic sfp_is_protected(input logic [1:0] bp, input logic [8:0] addr);
        logic hit;
        hit = 1'b0;
        case (bp)
            BP_NONE:    hit = 1'b0;
            BP_QUARTER: hit = (addr >= PROT_QUARTER_BASE);
            BP_HALF:    hit = (addr >= PROT_HALF_BASE);
            BP_ALL:     hit = 1'b1;
            default:    hit = 1'b1;
        endcase
        return hit;
    endfunction : sfp_is_protected

endpackage : sfp_pkg
